// ---- shared/lbs_consts.vh ----
`ifndef LBS_CONSTS_VH
`define LBS_CONSTS_VH

// Register byte offsets on the Wishbone slave.
`define LBS_REG_CTRL 8'h00
`define LBS_REG_STATUS 8'h04

// Control register fields.
`define LBS_CTRL_MODE_LSB 0
`define LBS_CTRL_MODE_W 2

// Software mode request codes.
`define LBS_REQ_AUTO 2'h0
`define LBS_REQ_INLINE 2'h1
`define LBS_REQ_BYPASS 2'h2
`define LBS_REQ_OPEN 2'h3

// Routing state codes reported in status bits 1:0.
`define LBS_ROUTE_OPEN 2'h0
`define LBS_ROUTE_INLINE 2'h1
`define LBS_ROUTE_BYPASS 2'h2

// Status register fields.
`define LBS_STAT_ROUTE_LSB 0
`define LBS_STAT_MODE_LSB 2
`define LBS_STAT_STRAP_BIT 4
`define LBS_STAT_PWR0_BIT 5
`define LBS_STAT_PWR1_BIT 6
`define LBS_STAT_FLASH_BIT 7

// Timing: clock period in ns and the times in their own units.
`define LBS_CLK_NS 20
`define LBS_HOLD_MS 10000
// Scaled in two steps so the intermediate product stays inside 32 bits.
`define LBS_HOLD_CYC (((`LBS_HOLD_MS * 1000) / `LBS_CLK_NS) * 1000)
`define LBS_FLASH_MS 2000
`define LBS_FLASH_CYC ((`LBS_FLASH_MS * 1000000) / `LBS_CLK_NS)
`define LBS_FILT_US 100
`define LBS_FILT_CYC ((`LBS_FILT_US * 1000) / `LBS_CLK_NS)

`endif

// ---- verilog/lbs_pwr_filter.v ----
`timescale 1ns/100ps
// Debounces a partner-power sense level: output changes only after the input
// has held a new value for FILT_CYC consecutive clocks.
module lbs_pwr_filter #(
  parameter integer FILT_CYC = 5000
) (
  input wire clk_i,
  input wire rst_i,
  input wire sense_i,
  output reg level_o
);
  reg [31:0] cnt_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
      level_o <= 1'b0;
    end else if (sense_i == level_o) begin
      cnt_q <= 32'h0;
    end else if (cnt_q >= FILT_CYC - 1) begin
      cnt_q <= 32'h0;
      level_o <= sense_i;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule

// ---- verilog/lbs_hold_timer.v ----
`timescale 1ns/100ps
// Counts how long all three front buttons are held; pulses once at HOLD_CYC,
// then stretches a display flash for FLASH_CYC cycles.
module lbs_hold_timer #(
  parameter integer HOLD_CYC = 500000000,
  parameter integer FLASH_CYC = 100000000
) (
  input wire clk_i,
  input wire rst_i,
  input wire [2:0] buttons_i,
  output reg fire_o,
  output reg flash_o
);
  reg [31:0] hold_q;
  reg [31:0] flash_q;
  wire all_held;

  assign all_held = &buttons_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 32'h0;
      flash_q <= 32'h0;
      fire_o <= 1'b0;
      flash_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      if (!all_held) begin
        hold_q <= 32'h0;
      end else if (hold_q < HOLD_CYC) begin
        hold_q <= hold_q + 32'h1;
        // A single reset event per press, even if the buttons stay down.
        if (hold_q == HOLD_CYC - 1) begin
          fire_o <= 1'b1;
        end
      end
      if (fire_o) begin
        flash_q <= FLASH_CYC;
        flash_o <= 1'b1;
      end else if (flash_q > 32'h1) begin
        flash_q <= flash_q - 32'h1;
      end else begin
        flash_q <= 32'h0;
        flash_o <= 1'b0;
      end
    end
  end
endmodule

// ---- verilog/lbs_switch_ctrl.v ----
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`include "lbs_consts.vh"
// How it works
// - Two external connectors join the internal strings.
// - Strap picks automatic or forced inline base.
// - Default strap gives automatic mode.
// - Commands force inline, bypass, open only in automatic.
// - Each card keeps its own mode.
// - Automatic: any powered partner gives inline.
// - Automatic: no powered partner gives bypass.
// - Automatic: partner power loss drops into bypass.
// - All automatic, unattached cards close one loop.
// - Forced inline: mode light green, ready lights off.
// - Forced inline ignores partner presence and power.
// - Strapped inline ignores all mode commands.
// - Forced bypass joins strings, ignores external side.
// - Forced open connects nothing at all.
module lbs_switch_ctrl #(
  parameter integer HOLD_CYC = `LBS_HOLD_CYC,
  parameter integer FLASH_CYC = `LBS_FLASH_CYC,
  parameter integer FILT_CYC = `LBS_FILT_CYC
) (
  input wire clk_i,
  input wire rst_i,
  // Classic Wishbone slave.
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire err_o,
  // Strap: high selects forced inline, low (default, pulled) is automatic.
  input wire strap_inline_i,
  input wire [1:0] partner_pwr_i,
  input wire [2:0] front_select_buttons_i,
  // Switch steering: ext_en_o routes internal links to connector n.
  output reg [1:0] ext_en_o,
  output reg loop_join_o,
  output reg mode_led_green_o,
  output reg mode_led_amber_o,
  output reg [1:0] ready_led_o,
  output wire display_flash_o
);
  // Route state codes; the same codes are reported in the status word.
  localparam [1:0] ST_OPEN = `LBS_ROUTE_OPEN;
  localparam [1:0] ST_INLINE = `LBS_ROUTE_INLINE;
  localparam [1:0] ST_BYPASS = `LBS_ROUTE_BYPASS;

  reg strap_q;
  reg [1:0] req_q;
  reg [1:0] req_d;
  reg [1:0] route_q;
  reg [1:0] route_d;
  reg ack_d;
  reg [31:0] rdata_d;
  reg [1:0] ext_en_d;
  reg loop_join_d;
  reg mode_led_green_d;
  reg mode_led_amber_d;
  reg [1:0] ready_led_d;
  wire [1:0] pwr_f;
  wire [1:0] conn_route;
  wire [1:0] conn_live;
  wire any_pwr;
  wire reset_fire;
  wire eff_inline;
  wire cmd_forced;
  wire wr_ctrl;
  wire rd_req;
  wire hit;

  // Returns true when the byte address maps to a register.
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `LBS_REG_CTRL) || (a == `LBS_REG_STATUS);
    end
  endfunction

  // Returns true when the byte address selects the control register.
  function is_ctrl;
    input [7:0] a;
    begin
      is_ctrl = (a == `LBS_REG_CTRL);
    end
  endfunction

  // True for the route state that hands the internal links to the connectors.
  function route_is_ext;
    input [1:0] r;
    begin
      route_is_ext = (r == ST_INLINE);
    end
  endfunction

  // True for the route state that closes the internal loop on the card.
  function route_is_join;
    input [1:0] r;
    begin
      route_is_join = (r == ST_BYPASS);
    end
  endfunction

  // True for a software request that overrides automatic switching.
  function req_is_forced;
    input [1:0] q;
    begin
      req_is_forced = (q != `LBS_REQ_AUTO);
    end
  endfunction

  // Each connector's sense is filtered on its own; a brief sag on one cable
  // must not flip the whole card between inline and bypass.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_conn
      lbs_pwr_filter #(
        .FILT_CYC(FILT_CYC)
      ) u_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sense_i(partner_pwr_i[g]),
        .level_o(pwr_f[g])
      );
    end
  endgenerate

  // The manual reset only clears software requests; a strapped card keeps its
  // forced inline mode because the strap overrides the request anyway.
  lbs_hold_timer #(
    .HOLD_CYC(HOLD_CYC),
    .FLASH_CYC(FLASH_CYC)
  ) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .buttons_i(front_select_buttons_i),
    .fire_o(reset_fire),
    .flash_o(display_flash_o)
  );

  // The strap is captured each clock so a jumper change takes effect without
  // a power cycle; it is static in practice.
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= 1'b0;
    end else begin
      strap_q <= strap_inline_i;
    end
  end

  assign hit = cyc_i && stb_i;
  // The slave never signals an error; unmapped reads return zero.
  assign err_o = 1'b0;
  // A write lands on the first edge of a request, the edge that raises ack.
  assign wr_ctrl = hit && we_i && sel_i[0] && !ack_o && is_ctrl(adr_i);

  // Software mode request, private to this card. The strap and the manual
  // reset both win over a write in the same cycle, so a late command can never
  // leave a strapped card, or one just reset by hand, in a forced mode.
  always @* begin
    req_d = req_q;
    if (strap_q) begin
      req_d = `LBS_REQ_AUTO;
    end else if (reset_fire) begin
      req_d = `LBS_REQ_AUTO;
    end else if (wr_ctrl) begin
      req_d = dat_i[`LBS_CTRL_MODE_LSB +: `LBS_CTRL_MODE_W];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= `LBS_REQ_AUTO;
    end else begin
      req_q <= req_d;
    end
  end

  assign cmd_forced = req_is_forced(req_q);

  assign eff_inline = strap_q || (req_q == `LBS_REQ_INLINE);
  assign any_pwr = |pwr_f;

  // Route state machine. Every state may move to any other in one step; the
  // target depends only on the mode and, in automatic mode, on partner power.
  // The case on the present state keeps the power loss path explicit.
  always @* begin
    route_d = ST_BYPASS;
    if (eff_inline) begin
      route_d = ST_INLINE;
    end else begin
      case (req_q)
        `LBS_REQ_BYPASS: route_d = ST_BYPASS;
        `LBS_REQ_OPEN: route_d = ST_OPEN;
        `LBS_REQ_AUTO: begin
          case (route_q)
            ST_INLINE: begin
              if (!any_pwr) begin
                // Last powered partner gone: close the loop around it.
                route_d = ST_BYPASS;
              end else begin
                route_d = ST_INLINE;
              end
            end
            ST_BYPASS: begin
              if (any_pwr) begin
                route_d = ST_INLINE;
              end else begin
                route_d = ST_BYPASS;
              end
            end
            ST_OPEN: begin
              route_d = any_pwr ? ST_INLINE : ST_BYPASS;
            end
            default: begin
              route_d = ST_BYPASS;
            end
          endcase
        end
        default: route_d = ST_BYPASS;
      endcase
    end
  end

  // Per-connector steering: both connectors follow the route together, and a
  // ready light needs a live partner on a connector that is actually routed.
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_steer
      assign conn_route[g] = route_is_ext(route_d);
      assign conn_live[g] = pwr_f[g] && route_is_ext(route_d);
    end
  endgenerate

  always @* begin
    ext_en_d = conn_route;
    loop_join_d = route_is_join(route_d);
    mode_led_green_d = eff_inline;
    mode_led_amber_d = !eff_inline && cmd_forced;
    // Ready lights show a live partner only while switching is automatic.
    if (eff_inline) begin
      ready_led_d = 2'h0;
    end else begin
      ready_led_d = conn_live;
    end
  end

  // The route is kept as state so that a power loss is seen as a move out of
  // inline rather than as a fresh decision.
  always @(posedge clk_i) begin
    if (rst_i) begin
      route_q <= ST_BYPASS;
    end else begin
      route_q <= route_d;
    end
  end

  // Both connectors switch together when inline.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_en_o <= 2'h0;
    end else begin
      ext_en_o <= ext_en_d;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      loop_join_o <= 1'b1;
    end else begin
      loop_join_o <= loop_join_d;
    end
  end

  // The mode lights follow the effective mode, not the route.
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_led_green_o <= 1'b0;
      mode_led_amber_o <= 1'b0;
    end else begin
      mode_led_green_o <= mode_led_green_d;
      mode_led_amber_o <= mode_led_amber_d;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_led_o <= 2'h0;
    end else begin
      ready_led_o <= ready_led_d;
    end
  end

  // One wait state: ack one cycle after the request, dropped the next cycle.
  // The second cycle of a held request is never taken again, so a master that
  // keeps stb up for the ack edge cannot write twice.
  always @* begin
    ack_d = hit && !ack_o;
  end

  assign rd_req = ack_d && !we_i && is_mapped(adr_i);

  // Read word, zero for writes and for addresses outside the map.
  always @* begin
    rdata_d = 32'h0;
    if (rd_req) begin
      case (adr_i)
        `LBS_REG_CTRL: begin
          rdata_d[`LBS_CTRL_MODE_LSB +: `LBS_CTRL_MODE_W] = req_q;
        end
        `LBS_REG_STATUS: begin
          rdata_d[`LBS_STAT_ROUTE_LSB +: 2] = route_q;
          rdata_d[`LBS_STAT_MODE_LSB +: 2] = req_q;
          rdata_d[`LBS_STAT_STRAP_BIT] = strap_q;
          rdata_d[`LBS_STAT_PWR0_BIT] = pwr_f[0];
          rdata_d[`LBS_STAT_PWR1_BIT] = pwr_f[1];
          rdata_d[`LBS_STAT_FLASH_BIT] = display_flash_o;
        end
        default: begin
          rdata_d = 32'h0;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= ack_d;
    end
  end

  // Read data is cleared outside the ack cycle so stale words never linger.
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else begin
      dat_o <= rdata_d;
    end
  end
endmodule

// ---- verif/lbs_switch_ctrl_properties.sv ----
`timescale 1ns/100ps
module lbs_switch_ctrl_chk #(
  parameter integer HOLD_CYC = 20,
  parameter integer FLASH_CYC = 8,
  parameter integer FILT_CYC = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire strap_inline_i,
  input wire ack_o,
  input wire err_o,
  input wire [1:0] ext_en_o,
  input wire loop_join_o,
  input wire mode_led_green_o,
  input wire mode_led_amber_o,
  input wire [1:0] ready_led_o,
  input wire display_flash_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s; cyc_i && stb_i && !ack_o; endsequence
  sequence flash_s; display_flash_o [*8] ##1 !display_flash_o; endsequence
  a_ack_after_req: assert property (req_s |=> ack_o) else $error("no ack one cycle after request");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_err_never: assert property (!err_o) else $error("error response seen");
  a_route_exclusive:
    assert property (ext_en_o != 2'h0 |-> !loop_join_o) else $error("inline and bypass together");
  a_green_dark:
    assert property (mode_led_green_o |-> ready_led_o == 2'h0) else $error("ready lit in forced inline");
  a_strap_forces:
    assert property (strap_inline_i [*3] |=> mode_led_green_o && !mode_led_amber_o) else $error("strap ignored");
  a_flash_len:
    assert property ($rose(display_flash_o) |-> flash_s) else $error("flash length wrong");
  a_light_clash:
    assert property (!(mode_led_green_o && mode_led_amber_o)) else $error("both mode lights on");
  a_open_amber:
    assert property (ext_en_o == 2'h0 && !loop_join_o |-> mode_led_amber_o) else $error("open without command");
  a_ready_inline:
    assert property (ready_led_o != 2'h0 |-> ext_en_o == 2'h3 || $past(ext_en_o) == 2'h3)
      else $error("ready lit while not inline");
endmodule
bind lbs_switch_ctrl lbs_switch_ctrl_chk #(.HOLD_CYC(HOLD_CYC), .FLASH_CYC(FLASH_CYC), .FILT_CYC(FILT_CYC)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .strap_inline_i(strap_inline_i),
  .ack_o(ack_o), .err_o(err_o), .ext_en_o(ext_en_o), .loop_join_o(loop_join_o),
  .mode_led_green_o(mode_led_green_o), .mode_led_amber_o(mode_led_amber_o),
  .ready_led_o(ready_led_o), .display_flash_o(display_flash_o));

// ---- verif/lbs_partner.sv ----
`timescale 1ns/100ps
module lbs_partner (
  input wire clk_i,
  input wire [1:0] on_i,
  input wire dip_i,
  output reg [1:0] pwr_o
);
  initial pwr_o = 2'h0;
  // A dip is a short brown-out of both partners that the card must ride through.
  always @(posedge clk_i) begin
    pwr_o <= dip_i ? 2'h0 : on_i;
  end
endmodule

// ---- verif/lbs_switch_ctrl_test.sv ----
`timescale 1ns/100ps
`include "lbs_consts.vh"
module lbs_switch_ctrl_test;
  reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, strap = 0, dip = 0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wd = 32'h0, rd;
  reg [1:0] on = 2'h0;
  reg [2:0] btn = 3'h0;
  wire [31:0] dat;
  wire ack, err, join_o, grn, amb, flash;
  wire [1:0] pwr, ext, rdy;
  integer num_errors = 0, num_checks = 0, i;
  localparam [14:0] FT = {5'h01, 5'h05, 5'h1A};
  always #10 clk_i = ~clk_i;
  lbs_partner far_u (.clk_i(clk_i), .on_i(on), .dip_i(dip), .pwr_o(pwr));
  lbs_switch_ctrl #(.HOLD_CYC(20), .FLASH_CYC(8), .FILT_CYC(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i(wd), .dat_o(dat), .ack_o(ack), .err_o(err), .strap_inline_i(strap), .partner_pwr_i(pwr),
    .front_select_buttons_i(btn), .ext_en_o(ext), .loop_join_o(join_o), .mode_led_green_o(grn),
    .mode_led_amber_o(amb), .ready_led_o(rdy), .display_flash_o(flash));
  task end_sim;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = dat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task outs(input [4:0] e);
    chk({27'h0, ext, join_o, grn, amb}, {27'h0, e});
  endtask
  initial begin
    #200000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    wt(16);
    rst_i <= 1'b0;
    wt(3);
    outs(5'h04);
    wb(1'b0, `LBS_REG_STATUS, 32'h0);
    chk(rd & 32'hFF, 32'h02);
    on <= 2'h1;
    wt(8);
    outs(5'h18);
    chk({30'h0, rdy}, 32'h1);
    dip <= 1'b1;
    wt(2);
    dip <= 1'b0;
    wt(2);
    outs(5'h18);
    on <= 2'h0;
    wt(8);
    outs(5'h04);
    on <= 2'h3;
    for (i = 1; i < 4; i = i + 1) begin
      wb(1'b1, `LBS_REG_CTRL, i);
      wt(3);
      outs(FT[i*5-5 +: 5]);
      chk({30'h0, rdy}, 32'h0);
      wb(1'b0, `LBS_REG_STATUS, 32'h0);
      chk(rd & 32'h0C, i << 2);
    end
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    strap <= 1'b1;
    wt(4);
    outs(5'h1A);
    wb(1'b1, `LBS_REG_CTRL, 32'h2);
    wt(3);
    outs(5'h1A);
    strap <= 1'b0;
    wt(4);
    outs(5'h18);
    wb(1'b1, `LBS_REG_CTRL, 32'h3);
    wt(3);
    btn <= 3'h7;
    wt(25);
    chk({31'h0, flash}, 32'h1);
    btn <= 3'h0;
    wt(12);
    outs(5'h18);
    chk({31'h0, flash}, 32'h0);
    end_sim;
  end
endmodule
